/* File: bench/enclave_gate_tb_top.sv */
`timescale 1ns/1ns
module enclave_gate_tb_top;
  import encl_gate_pkg::*;
  localparam seg_t FS0 = {12'h093, 32'h0000_FFFF, 64'h0000_0000_0000_4000};
  localparam seg_t GS0 = {12'h093, 32'h0000_FFFF, 64'h0000_0000_0000_8000};
  localparam logic [63:0] FC_ALL = (64'h1 << FC_EN_BIT) | (64'h1 << FC_LEWR_BIT) | (64'h1 << FC_LOCK_BIT);
  logic mclk_in = 1'b0, srst_in = 1'b1, msr_req_in = 1'b0, msr_we_in = 1'b0, cap_req_in = 1'b0;
  logic cap_base_set_in = 1'b1, cap_lc_in = 1'b1, prot_mode_in = 1'b1, smm_in = 1'b0, v86_in = 1'b0;
  logic paging_in = 1'b1, long64_in = 1'b1, op_valid_in = 1'b0, opsize_pfx_in = 1'b0, aex_in = 1'b0;
  logic ds_usable_in = 1'b1, ds_expdown_in = 1'b0, base_nz_in = 1'b0, cs_wide_mode_attr_in = 1'b1;
  logic enclave_control_struct_wide_mode_attr_in = 1'b1, epc_ok_in = 1'b1;
  logic [1:0] cpl_in = 2'h3;
  logic [11:0] ds_attr_in = 12'h093;
  logic [31:0] msr_idx_in = 32'h0, cap_leaf_in = 32'h0, cap_sub_in = 32'h0, ds_limit_in = 32'hFFFF_FFFF;
  logic [31:0] tcs_fs_lim_in = 32'h0000_0FFF, tcs_gs_lim_in = 32'h0000_0FFF;
  logic [63:0] msr_wdata_in = 64'h0, op_offset_in = 64'h0, ds_base_in = 64'h0, enclave_control_struct_base_in = 64'h0001_0000;
  logic [63:0] tcs_fs_ofs_in = 64'h100, tcs_gs_ofs_in = 64'h200, ssa_fs_base_in = 64'h0;
  logic [63:0] ssa_gs_base_in = 64'h0, wr_base_in = 64'h0;
  op_kind_e op_kind_in = OPK_NONE;
  leaf_t leaf_in = 4'h0;
  logic msr_ack_out, msr_gp_out, cap_ack_out, done_out, ud_out, gp_out, pg_check_out, ad_set_out;
  logic seg_load_out, ssa_save_out, in_encl_out, avail_out;
  logic [63:0] msr_rdata_out, lin_addr_out, ssa_fs_base_out, ssa_gs_base_out;
  logic [31:0] cap_eax_out, cap_ecx_out;
  seg_t fs_seg_out, gs_seg_out, fs_cur_in, gs_cur_in;
  int err_total = 0;
  int n_checks = 0;

  enclave_gate enclave_gate_inst (.mclk_in, .srst_in, .msr_req_in, .msr_we_in, .msr_idx_in, .msr_wdata_in,
    .msr_ack_out, .msr_gp_out, .msr_rdata_out, .cap_req_in, .cap_leaf_in, .cap_sub_in, .cap_base_set_in,
    .cap_lc_in, .cap_ack_out, .cap_eax_out, .cap_ecx_out, .prot_mode_in, .smm_in, .v86_in, .paging_in,
    .long64_in, .op_valid_in, .op_kind_in, .leaf_in, .opsize_pfx_in, .op_offset_in, .ds_base_in,
    .ds_limit_in, .ds_attr_in, .ds_usable_in, .ds_expdown_in, .base_nz_in, .cs_wide_mode_attr_in, .cpl_in,
    .enclave_control_struct_wide_mode_attr_in, .enclave_control_struct_base_in, .tcs_fs_ofs_in, .tcs_gs_ofs_in, .tcs_fs_lim_in, .tcs_gs_lim_in,
    .ssa_fs_base_in, .ssa_gs_base_in, .fs_cur_in, .gs_cur_in, .wr_base_in, .aex_in, .epc_ok_in, .done_out,
    .ud_out, .gp_out, .lin_addr_out, .pg_check_out, .ad_set_out, .seg_load_out, .fs_seg_out, .gs_seg_out,
    .ssa_save_out, .ssa_fs_base_out, .ssa_gs_base_out, .in_encl_out, .avail_out);

  pipe_model #(.FS_INIT(FS0), .GS_INIT(GS0)) pipe_model_inst (.mclk_in, .srst_in, .op_valid_in,
    .op_kind_in, .wr_base_in, .done_in(done_out), .ud_in(ud_out), .seg_load_in(seg_load_out),
    .fs_seg_in(fs_seg_out), .gs_seg_in(gs_seg_out), .fs_cur_out(fs_cur_in), .gs_cur_out(gs_cur_in));

  initial begin
    forever #20 mclk_in = ~mclk_in;
  end

  task automatic final_report;
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic msr(input logic we, input logic [31:0] idx, input logic [63:0] wd, input logic egp);
    @(negedge mclk_in);
    msr_req_in = 1'b1;
    msr_we_in = we;
    msr_idx_in = idx;
    msr_wdata_in = wd;
    @(negedge mclk_in);
    msr_req_in = 1'b0;
    @(negedge mclk_in);
    chk(msr_ack_out, 1'b1);
    chk(msr_gp_out, egp);
  endtask

  task automatic cap(input logic [31:0] leaf);
    @(negedge mclk_in);
    cap_req_in = 1'b1;
    cap_leaf_in = leaf;
    @(negedge mclk_in);
    cap_req_in = 1'b0;
    chk(cap_ack_out, 1'b1);
  endtask

  task automatic op(input op_kind_e k, input leaf_t lf, input logic eud, input logic egp);
    @(negedge mclk_in);
    op_valid_in = 1'b1;
    op_kind_in = k;
    leaf_in = lf;
    @(negedge mclk_in);
    op_valid_in = 1'b0;
    chk(done_out, 1'b1);
    chk(ud_out, eud);
    chk(gp_out, egp);
  endtask

  initial begin
    repeat (2000) @(posedge mclk_in);
    err_total++;
    final_report();
  end

  initial begin
    repeat (16) @(negedge mclk_in);
    srst_in = 1'b0;
    msr(1'b0, MSR_FC_IDX, 64'h0, 1'b0);
    chk(msr_rdata_out, 64'h0);
    chk(avail_out, 1'b0);
    msr(1'b1, MSR_HASH_IDX, 64'h0000_0000_0000_00A5, 1'b1);
    msr(1'b1, MSR_FC_IDX, FC_ALL & ~64'h1, 1'b0);
    chk(avail_out, 1'b0);
    msr(1'b1, MSR_FC_IDX, 64'hFFFF_FFFF_FFFF_FFFF, 1'b0);
    msr(1'b0, MSR_FC_IDX, 64'h0, 1'b0);
    chk(msr_rdata_out, FC_ALL);
    chk(avail_out, 1'b1);
    msr(1'b1, MSR_FC_IDX, 64'h0, 1'b1);
    msr(1'b1, MSR_HASH_IDX + 32'h1, 64'h1234_5678_9ABC_DEF0, 1'b0);
    msr(1'b0, MSR_HASH_IDX + 32'h1, 64'h0, 1'b0);
    chk(msr_rdata_out, 64'h1234_5678_9ABC_DEF0);
    msr(1'b0, MSR_HASH_IDX, 64'h0, 1'b0);
    chk(msr_rdata_out, 64'h0);
    msr(1'b0, 32'h0000_0200, 64'h0, 1'b1);
    cap_lc_in = 1'b0;
    msr(1'b0, MSR_HASH_IDX, 64'h0, 1'b1);
    cap(CAP_LEAF_EXT);
    chk(cap_ecx_out, 32'h0);
    cap_lc_in = 1'b1;
    cap(CAP_LEAF_EXT);
    chk(cap_ecx_out, 32'h4000_0000);
    cap(CAP_LEAF_ENCL);
    chk(cap_eax_out, 32'h0000_0001);
    ds_base_in = 64'h0000_0001_0000_0000;
    op_offset_in = 64'h40;
    op(OPK_USER, 4'h0, 1'b0, 1'b0);
    chk(lin_addr_out, 64'h0000_0001_0000_0040);
    chk(pg_check_out, 1'b1);
    chk(ad_set_out, 1'b1);
    long64_in = 1'b0;
    ds_base_in = 64'h0000_0000_FFFF_FFF0;
    op_offset_in = 64'h20;
    op(OPK_USER, 4'h0, 1'b0, 1'b0);
    chk(lin_addr_out, 64'h10);
    long64_in = 1'b1;
    ds_base_in = 64'h0;
    opsize_pfx_in = 1'b1;
    op(OPK_USER, 4'h0, 1'b1, 1'b0);
    opsize_pfx_in = 1'b0;
    paging_in = 1'b0;
    op(OPK_USER, 4'h0, 1'b1, 1'b0);
    op(OPK_SUPER, LEAF_DBG_RD, 1'b0, 1'b0);
    op(OPK_SUPER, LEAF_DBG_WR, 1'b0, 1'b0);
    paging_in = 1'b1;
    ds_expdown_in = 1'b1;
    op(OPK_SUPER, 4'h0, 1'b0, 1'b1);
    ds_expdown_in = 1'b0;
    ds_usable_in = 1'b0;
    op(OPK_USER, 4'h0, 1'b0, 1'b1);
    chk(ad_set_out, 1'b1);
    ds_usable_in = 1'b1;
    prot_mode_in = 1'b0;
    op(OPK_USER, 4'h0, 1'b1, 1'b0);
    prot_mode_in = 1'b1;
    smm_in = 1'b1;
    op(OPK_USER, 4'h0, 1'b1, 1'b0);
    smm_in = 1'b0;
    v86_in = 1'b1;
    op(OPK_SUPER, 4'h0, 1'b1, 1'b0);
    v86_in = 1'b0;
    cpl_in = 2'h0;
    op(OPK_USER, LEAF_ENTER, 1'b0, 1'b1);
    cpl_in = 2'h3;
    cs_wide_mode_attr_in = 1'b0;
    op(OPK_USER, LEAF_ENTER, 1'b0, 1'b1);
    cs_wide_mode_attr_in = 1'b1;
    base_nz_in = 1'b1;
    op(OPK_USER, LEAF_RESUME, 1'b0, 1'b1);
    base_nz_in = 1'b0;
    op(OPK_USER, LEAF_ENTER, 1'b0, 1'b0);
    chk(seg_load_out, 1'b1);
    chk(in_encl_out, 1'b1);
    chk(fs_seg_out[63:0], 64'h0001_0100);
    chk({32'h0, fs_seg_out[95:64]}, 64'h0FFF);
    chk(gs_seg_out[63:0], 64'h0001_0200);
    op(OPK_SEGCHG, 4'h0, 1'b1, 1'b0);
    wr_base_in = 64'h7000;
    op(OPK_WRFS, 4'h0, 1'b0, 1'b0);
    @(negedge mclk_in);
    aex_in = 1'b1;
    @(negedge mclk_in);
    aex_in = 1'b0;
    chk(ssa_save_out, 1'b1);
    chk(ssa_fs_base_out, 64'h7000);
    chk(ssa_gs_base_out, 64'h0001_0200);
    chk(fs_seg_out[63:0], FS0[63:0]);
    chk(in_encl_out, 1'b0);
    ssa_fs_base_in = 64'h7000;
    op(OPK_USER, LEAF_RESUME, 1'b0, 1'b0);
    chk(fs_seg_out[63:0], 64'h7000);
    op(OPK_USER, LEAF_EXIT, 1'b0, 1'b0);
    chk(fs_seg_out[63:0], FS0[63:0]);
    chk(gs_seg_out[63:0], GS0[63:0]);
    chk(in_encl_out, 1'b0);
    final_report();
  end
endmodule

/* File: bench/pipe_model.sv */
`timescale 1ns/1ns
module pipe_model #(
  parameter encl_gate_pkg::seg_t FS_INIT = 108'h0,
  parameter encl_gate_pkg::seg_t GS_INIT = 108'h0
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic op_valid_in,
  input wire encl_gate_pkg::op_kind_e op_kind_in,
  input wire logic [63:0] wr_base_in,
  input wire logic done_in,
  input wire logic ud_in,
  input wire logic seg_load_in,
  input wire encl_gate_pkg::seg_t fs_seg_in,
  input wire encl_gate_pkg::seg_t gs_seg_in,
  output encl_gate_pkg::seg_t fs_cur_out,
  output encl_gate_pkg::seg_t gs_cur_out
);
  import encl_gate_pkg::*;
  op_kind_e kind_q;
  logic [63:0] wr_q;
  // Remember the op whose answer comes next
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      kind_q <= OPK_NONE;
      wr_q <= 64'h0;
    end else if (op_valid_in) begin
      kind_q <= op_kind_in;
      wr_q <= wr_base_in;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      fs_cur_out <= FS_INIT;
      gs_cur_out <= GS_INIT;
    end else if (seg_load_in) begin
      fs_cur_out <= fs_seg_in;
      gs_cur_out <= gs_seg_in;
    end else if (done_in && !ud_in && kind_q == OPK_WRFS) begin
      fs_cur_out[63:0] <= wr_q;
    end else if (done_in && !ud_in && kind_q == OPK_WRGS) begin
      gs_cur_out[63:0] <= wr_q;
    end
  end
endmodule

/* File: core/enclave_gate.sv */
`timescale 1ns/1ns
module enclave_gate (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic msr_req_in,
  input wire logic msr_we_in,
  input wire logic [31:0] msr_idx_in,
  input wire logic [63:0] msr_wdata_in,
  output logic msr_ack_out,
  output logic msr_gp_out,
  output logic [63:0] msr_rdata_out,
  input wire logic cap_req_in,
  input wire logic [31:0] cap_leaf_in,
  input wire logic [31:0] cap_sub_in,
  input wire logic cap_base_set_in,
  input wire logic cap_lc_in,
  output logic cap_ack_out,
  output logic [31:0] cap_eax_out,
  output logic [31:0] cap_ecx_out,
  input wire logic prot_mode_in,
  input wire logic smm_in,
  input wire logic v86_in,
  input wire logic paging_in,
  input wire logic long64_in,
  input wire logic op_valid_in,
  input wire encl_gate_pkg::op_kind_e op_kind_in,
  input wire encl_gate_pkg::leaf_t leaf_in,
  input wire logic opsize_pfx_in,
  input wire logic [63:0] op_offset_in,
  input wire logic [63:0] ds_base_in,
  input wire logic [31:0] ds_limit_in,
  input wire logic [encl_gate_pkg::ATTR_W-1:0] ds_attr_in,
  input wire logic ds_usable_in,
  input wire logic ds_expdown_in,
  input wire logic base_nz_in,
  input wire logic cs_wide_mode_attr_in,
  input wire logic [1:0] cpl_in,
  input wire logic enclave_control_struct_wide_mode_attr_in,
  input wire logic [63:0] enclave_control_struct_base_in,
  input wire logic [63:0] tcs_fs_ofs_in,
  input wire logic [63:0] tcs_gs_ofs_in,
  input wire logic [31:0] tcs_fs_lim_in,
  input wire logic [31:0] tcs_gs_lim_in,
  input wire logic [63:0] ssa_fs_base_in,
  input wire logic [63:0] ssa_gs_base_in,
  input wire encl_gate_pkg::seg_t fs_cur_in,
  input wire encl_gate_pkg::seg_t gs_cur_in,
  input wire logic [63:0] wr_base_in,
  input wire logic aex_in,
  input wire logic epc_ok_in,
  output logic done_out,
  output logic ud_out,
  output logic gp_out,
  output logic [63:0] lin_addr_out,
  output logic pg_check_out,
  output logic ad_set_out,
  output logic seg_load_out,
  output encl_gate_pkg::seg_t fs_seg_out,
  output encl_gate_pkg::seg_t gs_seg_out,
  output logic ssa_save_out,
  output logic [63:0] ssa_fs_base_out,
  output logic [63:0] ssa_gs_base_out,
  output logic in_encl_out,
  output logic avail_out
);
  import encl_gate_pkg::*;

  typedef struct packed {
    logic [63:0] fc;
    logic in_encl;
    logic encl64;
    seg_t fs_sav;
    seg_t gs_sav;
    seg_t fs_act;
    seg_t gs_act;
    logic done;
    logic ud;
    logic gp;
    logic [63:0] lin;
    logic pg_chk;
    logic ad_set;
    logic seg_load;
    logic ssa_save;
    logic [63:0] ssa_fs;
    logic [63:0] ssa_gs;
    logic msr_p;
    logic msr_p_hash;
    logic msr_p_gp;
    logic [63:0] msr_p_rd;
    logic msr_ack;
    logic msr_gp;
    logic [63:0] msr_rd;
    logic cap_ack;
    logic [31:0] cap_eax;
    logic [31:0] cap_ecx;
    logic avail;
  } gate_s;

  gate_s s_q;
  gate_s s_d;

  logic avail_c;
  logic hash_hit;
  logic hash_impl;
  logic hash_wr_ok;
  logic hash_we;
  logic [63:0] hash_rdata;
  logic is_encl;
  logic is_entry;
  logic is_resume;
  logic is_exit;
  logic is_dbg;
  logic ud_c;
  logic gp_c;
  logic entry_bad;
  seg_t new_fs;
  seg_t new_gs;
  logic [63:0] lin_c;

  function automatic logic inside_ds(input logic [63:0] b, input logic [31:0] l,
                                     input logic [63:0] db, input logic [31:0] dl);
    logic [32:0] hi;
    logic [32:0] dhi;
    hi = {1'b0, b[31:0]} + {1'b0, l};
    dhi = {1'b0, db[31:0]} + {1'b0, dl};
    return (b[31:0] >= db[31:0]) && (hi <= dhi);
  endfunction

  assign avail_c = s_q.fc[FC_EN_BIT] && s_q.fc[FC_LOCK_BIT] && prot_mode_in && !smm_in && !v86_in;

  assign hash_hit = msr_idx_in[31:HASH_AW] == MSR_HASH_IDX[31:HASH_AW];
  assign hash_impl = cap_base_set_in && cap_lc_in;
  assign hash_wr_ok = s_q.fc[FC_LEWR_BIT] && s_q.fc[FC_LOCK_BIT];
  assign hash_we = msr_req_in && msr_we_in && hash_hit && hash_impl && hash_wr_ok;

  assign is_encl = op_kind_in == OPK_USER || op_kind_in == OPK_SUPER;
  assign is_entry = op_kind_in == OPK_USER && (leaf_in == LEAF_ENTER || leaf_in == LEAF_RESUME);
  assign is_resume = op_kind_in == OPK_USER && leaf_in == LEAF_RESUME;
  assign is_exit = op_kind_in == OPK_USER && leaf_in == LEAF_EXIT;
  assign is_dbg = op_kind_in == OPK_SUPER && (leaf_in == LEAF_DBG_RD || leaf_in == LEAF_DBG_WR);

  assign new_fs = {ds_attr_in, tcs_fs_lim_in, is_resume ? ssa_fs_base_in : tcs_fs_ofs_in + enclave_control_struct_base_in};
  assign new_gs = {ds_attr_in, tcs_gs_lim_in, is_resume ? ssa_gs_base_in : tcs_gs_ofs_in + enclave_control_struct_base_in};

  assign entry_bad = is_entry && (s_q.in_encl || base_nz_in || cs_wide_mode_attr_in != enclave_control_struct_wide_mode_attr_in
    || cpl_in != CPL_USER
    || (!long64_in && !(inside_ds(new_fs[SEG_BASE_LSB +: BASE_W], tcs_fs_lim_in, ds_base_in, ds_limit_in)
    && inside_ds(new_gs[SEG_BASE_LSB +: BASE_W], tcs_gs_lim_in, ds_base_in, ds_limit_in))));

  assign ud_c = (is_encl && (!avail_c || (!paging_in && !is_dbg) || opsize_pfx_in))
    || (s_q.in_encl && (op_kind_in == OPK_SEGCHG
    || ((op_kind_in == OPK_WRFS || op_kind_in == OPK_WRGS) && !s_q.encl64)));

  assign gp_c = is_encl && (!ds_usable_in || ds_expdown_in || entry_bad || (is_exit && !s_q.in_encl));

  // offset within data segment, override ignored
  assign lin_c = long64_in ? ds_base_in + op_offset_in : {32'h0000_0000, ds_base_in[31:0] + op_offset_in[31:0]};

  key_hash_mem u_hash (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .we_in(hash_we),
    .waddr_in(msr_idx_in[HASH_AW-1:0]),
    .wdata_in(msr_wdata_in),
    .raddr_in(msr_idx_in[HASH_AW-1:0]),
    .rdata_out(hash_rdata)
  );

  always_comb begin
    s_d = s_q;
    s_d.avail = avail_c;
    s_d.done = 1'b0;
    s_d.ud = 1'b0;
    s_d.gp = 1'b0;
    s_d.pg_chk = 1'b0;
    s_d.ad_set = 1'b0;
    s_d.seg_load = 1'b0;
    s_d.ssa_save = 1'b0;
    s_d.msr_ack = 1'b0;
    s_d.msr_gp = 1'b0;
    s_d.msr_p = 1'b0;
    s_d.msr_p_hash = 1'b0;
    s_d.msr_p_gp = 1'b0;
    s_d.msr_p_rd = 64'h0000_0000_0000_0000;
    s_d.cap_ack = 1'b0;

    if (cap_req_in) begin
      s_d.cap_ack = 1'b1;
      s_d.cap_eax = 32'h0000_0000;
      s_d.cap_ecx = 32'h0000_0000;
      if (cap_leaf_in == CAP_LEAF_ENCL && cap_sub_in == CAP_SUB_ZERO) begin
        s_d.cap_eax[CAP_BASE_SET_BIT] = cap_base_set_in;
      end
      if (cap_leaf_in == CAP_LEAF_EXT && cap_sub_in == CAP_SUB_ZERO) begin
        s_d.cap_ecx[CAP_LC_BIT] = cap_lc_in;
      end
    end

    // Second stage waits for the hash memory's registered read
    if (s_q.msr_p) begin
      s_d.msr_ack = 1'b1;
      s_d.msr_gp = s_q.msr_p_gp;
      s_d.msr_rd = s_q.msr_p_hash ? hash_rdata : s_q.msr_p_rd;
    end

    if (msr_req_in) begin
      s_d.msr_p = 1'b1;
      if (msr_idx_in == MSR_FC_IDX) begin
        if (!msr_we_in) begin
          s_d.msr_p_rd = s_q.fc;
        end else if (s_q.fc[FC_LOCK_BIT]) begin
          s_d.msr_p_gp = 1'b1;
        end else begin
          s_d.fc = msr_wdata_in & FC_WR_MASK;
        end
      end else if (hash_hit && hash_impl) begin
        s_d.msr_p_gp = msr_we_in && !hash_wr_ok;
        s_d.msr_p_hash = !msr_we_in;
      end else begin
        s_d.msr_p_gp = 1'b1;
      end
    end

    if (op_valid_in && op_kind_in != OPK_NONE) begin
      s_d.done = 1'b1;
      s_d.ud = ud_c;
      s_d.gp = !ud_c && gp_c;
      s_d.lin = lin_c;
      s_d.pg_chk = is_encl && !ud_c && !gp_c && paging_in;
      // flags may update on page accesses without #UD, including ones that take #GP
      s_d.ad_set = is_encl && !ud_c && paging_in && epc_ok_in;
      if (!ud_c && !gp_c) begin
        if (is_entry) begin
          s_d.fs_sav = fs_cur_in;
          s_d.gs_sav = gs_cur_in;
          s_d.fs_act = new_fs;
          s_d.gs_act = new_gs;
          s_d.in_encl = 1'b1;
          s_d.encl64 = enclave_control_struct_wide_mode_attr_in;
          s_d.seg_load = 1'b1;
        end else if (is_exit) begin
          s_d.fs_act = s_q.fs_sav;
          s_d.gs_act = s_q.gs_sav;
          s_d.in_encl = 1'b0;
          s_d.seg_load = 1'b1;
        end else if (s_q.in_encl && op_kind_in == OPK_WRFS) begin
          s_d.fs_act[SEG_BASE_LSB +: BASE_W] = wr_base_in;
        end else if (s_q.in_encl && op_kind_in == OPK_WRGS) begin
          s_d.gs_act[SEG_BASE_LSB +: BASE_W] = wr_base_in;
        end
      end
    end else if (aex_in && s_q.in_encl) begin
      // bases go to the save frame
      s_d.ssa_save = 1'b1;
      s_d.ssa_fs = s_q.fs_act[SEG_BASE_LSB +: BASE_W];
      s_d.ssa_gs = s_q.gs_act[SEG_BASE_LSB +: BASE_W];
      s_d.fs_act = s_q.fs_sav;
      s_d.gs_act = s_q.gs_sav;
      s_d.in_encl = 1'b0;
      s_d.seg_load = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      s_q <= '0;
      s_q.fc <= FC_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign msr_ack_out = s_q.msr_ack;
  assign msr_gp_out = s_q.msr_gp;
  assign msr_rdata_out = s_q.msr_rd;
  assign cap_ack_out = s_q.cap_ack;
  assign cap_eax_out = s_q.cap_eax;
  assign cap_ecx_out = s_q.cap_ecx;
  assign done_out = s_q.done;
  assign ud_out = s_q.ud;
  assign gp_out = s_q.gp;
  assign lin_addr_out = s_q.lin;
  assign pg_check_out = s_q.pg_chk;
  assign ad_set_out = s_q.ad_set;
  assign seg_load_out = s_q.seg_load;
  assign fs_seg_out = s_q.fs_act;
  assign gs_seg_out = s_q.gs_act;
  assign ssa_save_out = s_q.ssa_save;
  assign ssa_fs_base_out = s_q.ssa_fs;
  assign ssa_gs_base_out = s_q.ssa_gs;
  assign in_encl_out = s_q.in_encl;
  assign avail_out = s_q.avail;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  sequence s_entry_req;
    op_valid_in && is_entry;
  endsequence

  sequence s_exit_ok;
    op_valid_in && is_exit && !ud_c && !gp_c;
  endsequence

  a_avail_gate: assert property (
    op_valid_in && is_encl && !(s_q.fc[FC_EN_BIT] && s_q.fc[FC_LOCK_BIT]) |=> done_out && ud_out)
    else $error("enclave op not refused while disabled");

  a_cap_hidden: assert property (
    cap_req_in && cap_leaf_in == CAP_LEAF_ENCL && cap_sub_in == CAP_SUB_ZERO
    |=> cap_ack_out && cap_eax_out[CAP_BASE_SET_BIT] == $past(cap_base_set_in))
    else $error("capability answer depends on feature bits");

  a_hash_ro: assert property (
    msr_req_in && msr_we_in && hash_hit && !hash_wr_ok |-> ##2 msr_ack_out && msr_gp_out)
    else $error("hash write accepted while read-only");

  a_opsize_ud: assert property (
    op_valid_in && is_encl && opsize_pfx_in |=> ud_out && !gp_out)
    else $error("operand-size prefix not faulted");

  a_addr_narrow: assert property (
    op_valid_in && op_kind_in != OPK_NONE && !long64_in |=> lin_addr_out[63:32] == 32'h0000_0000)
    else $error("narrow mode address exceeds 32 bits");

  a_ds_check: assert property (
    op_valid_in && is_encl && !ud_c && (!ds_usable_in || ds_expdown_in) |=> gp_out && !ud_out)
    else $error("bad data segment not faulted");

  a_entry_cpl: assert property (
    s_entry_req ##0 (cpl_in != CPL_USER) |=> (gp_out || ud_out) && !seg_load_out)
    else $error("entry allowed at wrong privilege");

  a_entry_fs: assert property (
    s_entry_req ##0 (leaf_in == LEAF_ENTER && !ud_c && !gp_c)
    |=> seg_load_out && fs_seg_out[SEG_BASE_LSB +: BASE_W] == $past(tcs_fs_ofs_in) + $past(enclave_control_struct_base_in))
    else $error("entry f base wrong");

  a_exit_restore: assert property (
    s_exit_ok |=> seg_load_out && !in_encl_out && fs_seg_out == $past(s_q.fs_sav))
    else $error("exit did not restore f segment");

  a_segchg_ud: assert property (
    op_valid_in && in_encl_out && op_kind_in == OPK_SEGCHG |=> ud_out ##1 !ud_out || op_valid_in)
    else $error("segment change inside enclave not faulted");

  a_nopg_ud: assert property (
    op_valid_in && is_encl && !is_dbg && !paging_in |=> done_out && ud_out)
    else $error("leaf ran with paging off");
endmodule

/* File: core/key_hash_mem.sv */
`timescale 1ns/1ns
module key_hash_mem (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic we_in,
  input wire logic [encl_gate_pkg::HASH_AW-1:0] waddr_in,
  input wire logic [63:0] wdata_in,
  input wire logic [encl_gate_pkg::HASH_AW-1:0] raddr_in,
  output logic [63:0] rdata_out
);
  import encl_gate_pkg::*;

  typedef struct packed {
    logic [HASH_CNT-1:0][63:0] word;
    logic [63:0] rdata;
  } mem_s;

  mem_s s_q;
  mem_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.rdata = s_q.word[raddr_in];
    if (we_in) begin
      s_d.word[waddr_in] = wdata_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      s_q.word <= {HASH_CNT{HASH_RESET}};
      s_q.rdata <= HASH_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_out = s_q.rdata;
endmodule

/* File: pkg/encl_gate_pkg.sv */
package encl_gate_pkg;
  // Feature-control bit positions
  localparam int FC_LOCK_BIT = 0;
  localparam int FC_LEWR_BIT = 17;
  localparam int FC_EN_BIT = 18;
  localparam logic [63:0] FC_RESET = 64'h0000_0000_0000_0000;
  // Only lock, write-enable and enable bits are writable; the rest read as zero
  localparam logic [63:0] FC_WR_MASK = 64'h0000_0000_0006_0001;

  // Register indices on the privileged register port
  localparam logic [31:0] MSR_FC_IDX = 32'h0000_0100;
  localparam logic [31:0] MSR_HASH_IDX = 32'h0000_0110;
  localparam int HASH_CNT = 4;
  localparam int HASH_AW = 2;
  localparam logic [63:0] HASH_RESET = 64'h0000_0000_0000_0000;

  // Capability query leaves and bits
  localparam logic [31:0] CAP_LEAF_ENCL = 32'h0000_0012;
  localparam logic [31:0] CAP_LEAF_EXT = 32'h0000_0007;
  localparam logic [31:0] CAP_SUB_ZERO = 32'h0000_0000;
  localparam int CAP_BASE_SET_BIT = 0;
  localparam int CAP_LC_BIT = 30;

  localparam logic [1:0] CPL_USER = 2'h3;

  // Segment descriptor: {attr, limit, base}
  localparam int BASE_W = 64;
  localparam int LIM_W = 32;
  localparam int ATTR_W = 12;
  localparam int SEG_BASE_LSB = 0;
  localparam int SEG_LIM_LSB = 64;
  localparam int SEG_ATTR_LSB = 96;
  typedef logic [ATTR_W+LIM_W+BASE_W-1:0] seg_t;

  // Leaf codes
  typedef logic [3:0] leaf_t;
  localparam leaf_t LEAF_ENTER = 4'h2;
  localparam leaf_t LEAF_RESUME = 4'h3;
  localparam leaf_t LEAF_EXIT = 4'h4;
  localparam leaf_t LEAF_DBG_RD = 4'h4;
  localparam leaf_t LEAF_DBG_WR = 4'h5;

  // Instruction classes presented by the pipeline
  typedef enum logic [2:0] {
    OPK_NONE,
    OPK_USER,
    OPK_SUPER,
    OPK_SEGCHG,
    OPK_WRFS,
    OPK_WRGS
  } op_kind_e;
endpackage
